// ---- bench/error_history_stack_asserts.sv ----
// checker: port-level properties of the error history stack
`timescale 1ns/10ps
module error_history_stack_chk #(
   parameter int DEPTH = 8
) (
   input wire logic                     i_ref_clk,
   input wire logic                     i_rst,
   input wire err_hist_pkg::err_event_t i_err,
   input wire logic [7:0]               i_active_cat,
   input wire err_hist_pkg::reg_req_t   i_req,
   input wire logic [31:0]              o_rdata,
   input wire logic                     o_abort,
   input wire logic [7:0]               o_summary,
   input wire logic                     o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   AST_ABORT_CODE: assert property (o_abort |-> o_rdata == err_hist_pkg::ABORT_NO_DATA)
      else $error("abort without its code");
   AST_ABORT_CAUSE: assert property (o_abort |-> $past(i_req.rd) &&
      $past(i_req.addr) inside {[8'h01:8'h08]}) else $error("abort without slot read");
   AST_COUNT_NO_ABORT: assert property (i_req.rd && i_req.addr == 8'h00 |=> !o_abort)
      else $error("count read refused");
   AST_IDLE_QUIET: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0 && !o_abort)
      else $error("answer without read");
   AST_PUSH_SLOT1: assert property (i_err.valid ##1 (i_req.rd && !i_err.valid &&
      i_req.addr == 8'h01) |=> o_rdata[31:24] == $past(i_err.num, 2) &&
      o_rdata[15:0] == $past(i_err.code, 2)) else $error("slot one not newest");
   AST_CLEAR_COUNT: assert property (i_req.wr && i_req.addr == 8'h00 &&
      i_req.wdata == 32'h0 && !i_err.valid ##1 (i_req.rd && i_req.addr == 8'h00 &&
      !i_err.valid) |=> o_rdata == 32'h0) else $error("count not restarted");
   // ----------------------------------------------------------------------
   // summary byte
   // ----------------------------------------------------------------------
   AST_SUM_RESERVED: assert property (o_summary[6] == 1'b0)
      else $error("reserved summary bit set");
   AST_SUM_TRACK: assert property (o_summary == ($past(i_active_cat, 3) & 8'hBF))
      else $error("summary not following categories");
endmodule : error_history_stack_chk

bind error_history_stack error_history_stack_chk #(.DEPTH(DEPTH)) i_chk (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_err(i_err), .i_active_cat(i_active_cat),
   .i_req(i_req), .o_rdata(o_rdata), .o_abort(o_abort), .o_summary(o_summary),
   .o_irq(o_irq));

// ---- bench/od_master.sv ----
// partner model: object dictionary master on the word-indexed register port
`timescale 1ns/10ps
module od_master (
   input  wire logic             i_ref_clk,
   input  wire logic [31:0]      i_rdata,
   input  wire logic             i_abort,
   output err_hist_pkg::reg_req_t o_req
);
   initial o_req = '0;
   // strobes last one cycle; returning 1 ns past the edge keeps calls back to back
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      o_req.addr  <= a;
      o_req.wdata <= d;
      o_req.wr    <= 1'b1;
      @(posedge i_ref_clk);
      o_req.wr    <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ab);
      o_req.addr <= a;
      o_req.rd   <= 1'b1;
      @(posedge i_ref_clk);
      o_req.rd   <= 1'b0;
      // the answer stands only in this cycle
      #1;
      d  = i_rdata;
      ab = i_abort;
   endtask : rd
endmodule : od_master

// ---- bench/test_error_history_stack.sv ----
// testbench: scenarios for the error history stack
`timescale 1ns/10ps
module test_error_history_stack;
   logic                     i_ref_clk    = 1'b0;
   logic                     i_rst        = 1'b1;
   err_hist_pkg::err_event_t i_err        = '0;
   logic [7:0]               i_active_cat = 8'h00;
   err_hist_pkg::reg_req_t   req;
   logic [31:0]              o_rdata;
   logic                     o_abort;
   logic [7:0]               o_summary;
   logic                     o_irq;
   int                       err_total    = 0;
   int                       num_checks   = 0;
   logic [31:0]              d;
   logic                     ab;
   // numbers outside the current and voltage groups, so the class is the summary
   logic [7:0] nums [10] = '{8'h19, 8'h04, 8'h07, 8'h0A, 8'h0F, 8'h0E, 8'h1B, 8'h15,
                             8'h1E, 8'h2E};
   always #5 i_ref_clk = ~i_ref_clk;
   error_history_stack i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_err(i_err),
      .i_active_cat(i_active_cat), .i_req(req), .o_rdata(o_rdata), .o_abort(o_abort),
      .o_summary(o_summary), .o_irq(o_irq));
   od_master i_mst (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .i_abort(o_abort),
      .o_req(req));
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [31:0] rec(input int i);
      return {nums[i], 8'h05, 16'h1000 | 16'(i)};
   endfunction : rec
   task automatic push(input int i);
      i_err <= '{valid: 1'b1, num: err_hist_pkg::err_num_t'(nums[i]),
                 code: 16'h1000 | 16'(i)};
      @(posedge i_ref_clk);
      i_err.valid <= 1'b0;
      #1;
   endtask : push
   task automatic settle();
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask : settle
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      i_mst.rd(8'h00, d, ab);
      chk(d, 32'h0);
      for (int k = 1; k <= 8; k++) begin
         i_mst.rd(8'(k), d, ab);
         chk(d, err_hist_pkg::ABORT_NO_DATA);
         chk(ab, 1'b1);
      end
      chk(o_irq, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_stack();
      @(posedge i_ref_clk);
      i_active_cat <= 8'h45;
      repeat (5) @(posedge i_ref_clk);
      #1;
      chk(o_summary, 8'h05);
      // ten pushes in consecutive cycles overflow the eight slots
      for (int i = 0; i < 10; i++) push(i);
      for (int k = 1; k <= 8; k++) begin
         i_mst.rd(8'(k), d, ab);
         chk(d, rec(10 - k));
      end
      i_mst.rd(8'h00, d, ab);
      chk(d, 32'h0000_000A);
      i_mst.rd(8'h30, d, ab);
      chk({ab, d}, 33'h0);
      $display("test stack done");
   endtask : t_stack
   task automatic t_clear();
      i_mst.wr(8'h00, 32'h0000_0005);
      i_mst.rd(8'h00, d, ab);
      chk(d, 32'h0000_000A);
      i_mst.wr(8'h00, 32'h0);
      i_mst.rd(8'h00, d, ab);
      chk(d, 32'h0);
      i_mst.rd(8'h01, d, ab);
      chk({ab, d}, {1'b1, err_hist_pkg::ABORT_NO_DATA});
      $display("test clear done");
   endtask : t_clear
   task automatic t_irq();
      i_mst.wr(err_hist_pkg::IDX_IRQ_MSK, 32'h1);
      settle();
      chk(o_irq, 1'b1);
      // both events seen so far: pushes and refused slot reads
      i_mst.rd(err_hist_pkg::IDX_IRQ_ST, d, ab);
      chk(d, 32'h0000_0003);
      i_mst.rd(err_hist_pkg::IDX_ABORT, d, ab);
      chk(d, err_hist_pkg::ABORT_NO_DATA);
      i_mst.rd(err_hist_pkg::IDX_SUMMARY, d, ab);
      chk(d, 32'h0000_0005);
      i_mst.wr(err_hist_pkg::IDX_IRQ_ST, 32'h3);
      settle();
      chk(o_irq, 1'b0);
      i_mst.rd(err_hist_pkg::IDX_IRQ_ST, d, ab);
      chk(d, 32'h0);
      push(0);
      push(1);
      settle();
      chk(o_irq, 1'b1);
      i_mst.rd(8'h01, d, ab);
      chk(d, rec(1));
      i_mst.rd(8'h02, d, ab);
      chk(d, rec(0));
      i_mst.rd(8'h00, d, ab);
      chk(d, 32'h0000_0002);
      i_mst.wr(err_hist_pkg::IDX_IRQ_MSK, 32'h0);
      settle();
      chk(o_irq, 1'b0);
      $display("test interrupt done");
   endtask : t_irq
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      t_reset();
      t_stack();
      t_clear();
      t_irq();
      complete_run();
   end
   initial begin
      #200000;
      err_total++;
      $display("run cut short by time limit");
      complete_run();
   end
endmodule : test_error_history_stack

// ---- pkg/err_hist_pkg.sv ----
// package: constants, encodings and carriers of the error history stack
package err_hist_pkg;

   // ----------------------------------------------------------------------
   // register map (word index, byte address = 4 * index)
   // ----------------------------------------------------------------------
   localparam logic [7:0] IDX_COUNT   = 8'h00;
   localparam logic [7:0] IDX_SLOT_LO = 8'h01;
   localparam logic [7:0] IDX_SLOT_HI = 8'h08;
   localparam logic [7:0] IDX_SUMMARY = 8'h10;
   localparam logic [7:0] IDX_IRQ_ST  = 8'h11;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h12;
   localparam logic [7:0] IDX_ABORT   = 8'h13;

   localparam int         SLOTS       = 8;
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [31:0] SLOT_RST   = 32'h0000_0000;
   localparam logic [31:0] ABORT_NO_DATA = 32'h0800_0024;

   // ----------------------------------------------------------------------
   // record field positions
   // ----------------------------------------------------------------------
   localparam int NUM_MSB = 31;
   localparam int NUM_LSB = 24;
   localparam int CLS_MSB = 23;
   localparam int CLS_LSB = 16;
   localparam int COD_MSB = 15;
   localparam int COD_LSB = 0;

   // error summary bits
   localparam int SUM_GENERAL = 0;
   localparam int SUM_CURRENT = 1;
   localparam int SUM_VOLTAGE = 2;
   localparam int SUM_RESERVED = 6;

   // interrupt status bits
   localparam int IRQ_LOGGED  = 0;
   localparam int IRQ_ABORT   = 1;

   // ----------------------------------------------------------------------
   // error numbers
   // ----------------------------------------------------------------------
   typedef enum logic [7:0] {
      EN_WATCHDOG      = 8'h00,
      EN_SUPPLY_OVER   = 8'h01,
      EN_OUT_CURRENT   = 8'h02,
      EN_SUPPLY_UNDER  = 8'h03,
      EN_FIELDBUS      = 8'h04,
      EN_GUARD_LATE    = 8'h06,
      EN_SENSOR1       = 8'h07,
      EN_SENSOR2       = 8'h08,
      EN_SENSOR3       = 8'h09,
      EN_LIMIT_POS     = 8'h0A,
      EN_LIMIT_NEG     = 8'h0B,
      EN_OVERTEMP      = 8'h0C,
      EN_FOLLOW_ERR    = 8'h0D,
      EN_NVM_FULL      = 8'h0E,
      EN_MOTOR_BLOCKED = 8'h0F,
      EN_NVM_DAMAGED   = 8'h10,
      EN_PDO_LATE      = 8'h11,
      EN_SENSOR_N      = 8'h12,
      EN_PDO_LEN       = 8'h13,
      EN_PDO_OVERFLOW  = 8'h14,
      EN_NVM_RESTART   = 8'h15,
      EN_RATED_UNSET   = 8'h16,
      EN_ENCODER_CFG   = 8'h17,
      EN_MOTOR_CURRENT = 8'h18,
      EN_INTERNAL      = 8'h19,
      EN_DOUT_CURRENT  = 8'h1A,
      EN_SYNC_LEN      = 8'h1B,
      EN_SLIP          = 8'h1E,
      EN_REF_FACTOR    = 8'h20,
      EN_BALLAST       = 8'h28,
      EN_INTERLOCK     = 8'h2E
   } err_num_t;

   // standard error codes, a few of the common ones
   localparam logic [15:0] CODE_GENERAL = 16'h1000;
   localparam logic [15:0] CODE_CURRENT = 16'h2300;
   localparam logic [15:0] CODE_VOLTAGE = 16'h3100;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  num;
      logic [7:0]  cls;
      logic [15:0] code;
   } err_rec_t;

   typedef struct packed {
      logic        valid;
      err_num_t    num;
      logic [15:0] code;
   } err_event_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage : err_hist_pkg

// ---- rtl/error_history_stack.sv ----
// module: eight-deep error history stack with count, summary and interrupt
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: each new error goes to slot 1, slots 1 to 7 shift back one.
// RULE2: the record that sat in slot 8 is discarded on push.
// RULE3: reading slot 0 gives the number of errors recorded so far.
// RULE4: with no record held, reading slots 1 to 8 aborts with 08000024h.
// RULE5: writing zero to slot 0 restarts counting, history count becomes zero.
// RULE6: record bits 31 to 24 carry the error number.
// RULE7: record bits 23 to 16 carry the summary byte seen at logging; the code ORs in the category bits of the logged error number.
// RULE8: record bits 15 to 0 carry the 16-bit standard error code.
// RULE9: numbers 0 to 4: watchdog, overvoltage, overcurrent, undervoltage, fieldbus.
// RULE10: sensor faults are numbers 7, 8, 9 and 18 for higher sensors.
// RULE11: limit switches 10 and 11, overtemperature 12, following error 13.
// RULE12: storage full 14, damaged 16, restart warning 21.
// RULE13: blocked motor 15, motor current 24, digital output current 26.
// RULE14: fieldbus-specific errors use numbers 6, 17, 19, 20 and 27.
// RULE15: slip 30, ballast overload 40, interlock 46.
// RULE16: rated current unset 22, encoder setup 23, internal 25, reference 32.
// RULE17: summary bits follow active error categories and clear when gone.
// RULE18: reset clears every slot and the count to zero.
module error_history_stack #(
   parameter int DEPTH = err_hist_pkg::SLOTS
) (
   // clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst,
   // error source
   input  wire err_hist_pkg::err_event_t i_err,
   input  wire logic [7:0]               i_active_cat,
   // register port
   input  wire err_hist_pkg::reg_req_t   i_req,
   output logic [31:0]                   o_rdata,
   output logic                          o_abort,
   // status
   output logic [7:0]                    o_summary,
   output logic                          o_irq
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      err_hist_pkg::err_rec_t [DEPTH-1:0] slot;
      logic [7:0]                         count;
      logic [7:0]                         held;
      logic [7:0]                         summary;
      logic [7:0]                         cat_sync1;
      logic [7:0]                         cat_sync2;
      logic [1:0]                         irq_st;
      logic [1:0]                         irq_msk;
      logic [31:0]                        last_abort;
      logic [31:0]                        rdata;
      logic                               abort;
      logic                               irq;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] category(input err_hist_pkg::err_num_t n);
      logic [7:0] c;
      c = 8'h00;
      c[err_hist_pkg::SUM_GENERAL] = 1'b1;
      case (n)
         err_hist_pkg::EN_OUT_CURRENT,
         err_hist_pkg::EN_MOTOR_CURRENT,
         err_hist_pkg::EN_DOUT_CURRENT: c[err_hist_pkg::SUM_CURRENT] = 1'b1;
         err_hist_pkg::EN_SUPPLY_OVER,
         err_hist_pkg::EN_SUPPLY_UNDER: c[err_hist_pkg::SUM_VOLTAGE] = 1'b1;
         default: c = c;
      endcase
      return c;
   endfunction : category

   logic [7:0] slot_idx;
   logic       is_slot;
   logic       do_push;
   logic [1:0] irq_set;
   logic [7:0] held_inc;

   always_comb begin
      state_nxt = state_r;
      slot_idx  = i_req.addr - err_hist_pkg::IDX_SLOT_LO;
      is_slot   = (i_req.addr >= err_hist_pkg::IDX_SLOT_LO) &&
                  (i_req.addr <= err_hist_pkg::IDX_SLOT_HI);
      do_push   = i_err.valid;
      irq_set   = 2'b00;
      held_inc  = (state_r.held == 8'(DEPTH)) ? state_r.held : state_r.held + 8'h01;

      // summary mirrors live categories: set while active, cleared once gone
      state_nxt.cat_sync1 = i_active_cat;
      state_nxt.cat_sync2 = state_r.cat_sync1;
      state_nxt.summary   = state_r.cat_sync2;                          // RULE17
      state_nxt.summary[err_hist_pkg::SUM_RESERVED] = 1'b0;

      // ---------------------------------------------------------------- push
      if (do_push) begin
         for (int k = DEPTH - 1; k > 0; k--) begin
            state_nxt.slot[k] = state_r.slot[k-1];                      // RULE1 RULE2
         end
         state_nxt.slot[0].num  = 8'(i_err.num);                         // RULE6 RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16
         state_nxt.slot[0].cls  = state_r.summary | category(i_err.num); // RULE7
         state_nxt.slot[0].code = i_err.code;                            // RULE8
         state_nxt.count = (state_r.count == 8'hFF) ? 8'hFF : state_r.count + 8'h01;
         state_nxt.held  = held_inc;
         irq_set[err_hist_pkg::IRQ_LOGGED] = 1'b1;
      end

      // ---------------------------------------------------------------- read
      state_nxt.rdata = 32'h0000_0000;
      state_nxt.abort = 1'b0;
      if (i_req.rd) begin
         if (i_req.addr == err_hist_pkg::IDX_COUNT) begin
            state_nxt.rdata = {24'h00_0000, state_r.count};             // RULE3
         end else if (is_slot) begin
            if (state_r.held == 8'h00 || slot_idx >= 8'(DEPTH)) begin
               state_nxt.rdata      = err_hist_pkg::ABORT_NO_DATA;      // RULE4
               state_nxt.abort      = 1'b1;
               state_nxt.last_abort = err_hist_pkg::ABORT_NO_DATA;
               irq_set[err_hist_pkg::IRQ_ABORT] = 1'b1;
            end else begin
               state_nxt.rdata = state_r.slot[slot_idx[2:0]];
            end
         end else if (i_req.addr == err_hist_pkg::IDX_SUMMARY) begin
            state_nxt.rdata = {24'h00_0000, state_r.summary};
         end else if (i_req.addr == err_hist_pkg::IDX_IRQ_ST) begin
            state_nxt.rdata = {30'h0, state_r.irq_st};
         end else if (i_req.addr == err_hist_pkg::IDX_IRQ_MSK) begin
            state_nxt.rdata = {30'h0, state_r.irq_msk};
         end else if (i_req.addr == err_hist_pkg::IDX_ABORT) begin
            state_nxt.rdata = state_r.last_abort;
         end
      end

      // ---------------------------------------------------------------- write
      // a push in the same cycle as the clear still counts as one error
      if (i_req.wr) begin
         if (i_req.addr == err_hist_pkg::IDX_COUNT && i_req.wdata == 32'h0) begin
            state_nxt.count = do_push ? 8'h01 : 8'h00;                   // RULE5
            state_nxt.held  = do_push ? 8'h01 : 8'h00;
         end else if (i_req.addr == err_hist_pkg::IDX_IRQ_ST) begin
            state_nxt.irq_st = state_r.irq_st & ~i_req.wdata[1:0];
         end else if (i_req.addr == err_hist_pkg::IDX_IRQ_MSK) begin
            state_nxt.irq_msk = i_req.wdata[1:0];
         end
      end

      // set wins over a clear in the same cycle
      state_nxt.irq_st = state_nxt.irq_st | irq_set;
      state_nxt.irq    = |(state_nxt.irq_st & state_nxt.irq_msk);
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r            <= '0;                                      // RULE18
         state_r.count      <= err_hist_pkg::COUNT_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign o_rdata   = state_r.rdata;
   assign o_abort   = state_r.abort;
   assign o_summary = state_r.summary;
   assign o_irq     = state_r.irq;

endmodule : error_history_stack
